// ===== src/fmdu_pkg.sv
// Constants, state type and helpers shared by the floating multiply and divide unit
package fmdu_pkg;

    // ------------------------------------------------------------
    // Word layout: sign in the top bit, characteristic, fraction
    // ------------------------------------------------------------
    localparam int SIGN_BIT = 35;
    localparam int CHAR_HI = 34;
    localparam int CHAR_LO = 27;
    localparam int FRAC_HI = 26;
    localparam logic [4:0] FRAC_STEPS = 5'h1b;      // 27 fraction positions
    localparam logic [9:0] CHAR_BIAS = 10'h080;     // Excess 200 octal
    localparam logic [9:0] CHAR_NEG_BIAS = 10'h380; // Minus 200 octal
    localparam logic [9:0] CHAR_M27 = 10'h3e5;      // Minus 27 decimal

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] AC_LO_OFF = 8'h08;
    localparam logic [7:0] AC_HI_OFF = 8'h0c;
    localparam logic [7:0] MQ_LO_OFF = 8'h10;
    localparam logic [7:0] MQ_HI_OFF = 8'h14;
    localparam logic [7:0] SR_LO_OFF = 8'h18;
    localparam logic [7:0] SR_HI_OFF = 8'h1c;
    localparam int CTRL_START_BIT = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DCHK_BIT = 1;
    localparam int ST_HALT_BIT = 2;
    localparam int ST_OVF_BIT = 3;
    localparam int ST_UNF_BIT = 4;

    // Operation select written to CTRL bits 1:0
    localparam logic [1:0] OP_NORM_MUL = 2'h0;
    localparam logic [1:0] OP_UNNORM_MUL = 2'h1;
    localparam logic [1:0] OP_DIV_HALT = 2'h2;
    localparam logic [1:0] OP_DIV_PROCEED = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MUL,
        ST_MNORM,
        ST_DIV
    } fmdu_state_type;

    function automatic logic [26:0] fmdu_frac(input logic [35:0] w);
        fmdu_frac = w[FRAC_HI:0];
    endfunction : fmdu_frac

    function automatic logic [7:0] fmdu_char(input logic [35:0] w);
        fmdu_char = w[CHAR_HI:CHAR_LO];
    endfunction : fmdu_char

    // Characteristic arithmetic in 10 bits so range exits stay visible
    function automatic logic [9:0] fmdu_char_calc(input logic [7:0] a, input logic [7:0] b,
                                                  input logic sub, input logic [9:0] k);
        if (sub) begin
            fmdu_char_calc = {2'h0, a} - {2'h0, b} + k;
        end else begin
            fmdu_char_calc = {2'h0, a} + {2'h0, b} + k;
        end
    endfunction : fmdu_char_calc

endpackage : fmdu_pkg

// ===== src/fmdu_top.sv
// Floating multiply and divide datapath with its APB register slave
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps

module fmdu_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Machine status
    output logic machine_halt,
    output logic divide_check,
    output logic fp_overflow,
    output logic fp_underflow
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        fmdu_pkg::fmdu_state_type st;
        logic [1:0] op;
        logic [35:0] ac; // Sign, characteristic, fraction
        logic [35:0] mq;
        logic [35:0] sr;
        logic [27:0] rem;
        logic [4:0] sc;
        logic [7:0] rchar;
        logic dchk;
        logic halt;
        logic ovf;
        logic unf;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fmdu_regs_type;

    fmdu_regs_type r;
    fmdu_regs_type n;
    logic acc_phase;
    logic go;

    // Access phase and start strobe, decoded once for both processes
    assign acc_phase = psel && penable;
    assign go = acc_phase && r.pready && pwrite && (paddr == fmdu_pkg::CTRL_OFF)
                && pwdata[fmdu_pkg::CTRL_START_BIT] && (r.st == fmdu_pkg::ST_IDLE) && !r.halt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [53:0] prod;
        logic [53:0] hl;
        logic [9:0] ch;
        logic [9:0] mqc;
        logic [27:0] trial;
        logic [26:0] af;
        logic [26:0] df;
        logic sgn;
        logic big;
        logic q1;
        logic ge;
        logic busy;
        logic mapped;
        prod = '0;
        hl = '0;
        ch = '0;
        mqc = '0;
        trial = '0;
        af = fmdu_pkg::fmdu_frac(r.ac);
        df = fmdu_pkg::fmdu_frac(r.sr);
        sgn = 1'b0;
        big = 1'b0;
        q1 = 1'b0;
        ge = 1'b0;
        busy = (r.st != fmdu_pkg::ST_IDLE);
        mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;

        // Bus: one wait state, read data captured on the edge pready rises
        if (acc_phase && !r.pready) begin
            n.pready = 1'b1;
            n.pslverr = !mapped;
            n.prdata = 32'h0;
            if (!pwrite) begin
                unique case (paddr)
                    fmdu_pkg::CTRL_OFF: n.prdata = {30'h0, r.op};
                    fmdu_pkg::STATUS_OFF: n.prdata = {27'h0, r.unf, r.ovf, r.halt, r.dchk, busy};
                    fmdu_pkg::AC_LO_OFF: n.prdata = r.ac[31:0];
                    fmdu_pkg::AC_HI_OFF: n.prdata = {28'h0, r.ac[35:32]};
                    fmdu_pkg::MQ_LO_OFF: n.prdata = r.mq[31:0];
                    fmdu_pkg::MQ_HI_OFF: n.prdata = {28'h0, r.mq[35:32]};
                    fmdu_pkg::SR_LO_OFF: n.prdata = r.sr[31:0];
                    fmdu_pkg::SR_HI_OFF: n.prdata = {28'h0, r.sr[35:32]};
                    default: n.prdata = 32'h0;
                endcase
            end
        end

        // Writes land on the edge the master samples pready
        if (acc_phase && r.pready && pwrite) begin
            if (paddr == fmdu_pkg::STATUS_OFF) begin
                // Write one to clear; the datapath below may set again and wins
                if (pwdata[fmdu_pkg::ST_DCHK_BIT]) n.dchk = 1'b0;
                if (pwdata[fmdu_pkg::ST_HALT_BIT]) n.halt = 1'b0;
                if (pwdata[fmdu_pkg::ST_OVF_BIT]) n.ovf = 1'b0;
                if (pwdata[fmdu_pkg::ST_UNF_BIT]) n.unf = 1'b0;
            end
            // Operands are frozen while an operation runs
            if (!busy) begin
                unique case (paddr)
                    fmdu_pkg::AC_LO_OFF: n.ac[31:0] = pwdata;
                    fmdu_pkg::AC_HI_OFF: n.ac[35:32] = pwdata[3:0];
                    fmdu_pkg::MQ_LO_OFF: n.mq[31:0] = pwdata;
                    fmdu_pkg::MQ_HI_OFF: n.mq[35:32] = pwdata[3:0];
                    fmdu_pkg::SR_LO_OFF: n.sr[31:0] = pwdata;
                    fmdu_pkg::SR_HI_OFF: n.sr[35:32] = pwdata[3:0];
                    default: ;
                endcase
            end
        end

        // Datapath
        unique case (r.st)
            fmdu_pkg::ST_IDLE: begin
                if (go) begin
                    n.op = pwdata[1:0];
                    if (!pwdata[1]) begin
                        // Multiply: SR is the multiplicand, MQ the multiplier
                        sgn = r.sr[fmdu_pkg::SIGN_BIT] ^ r.mq[fmdu_pkg::SIGN_BIT];
                        n.ac[fmdu_pkg::SIGN_BIT] = sgn;
                        n.mq[fmdu_pkg::SIGN_BIT] = sgn;
                        if (pwdata[1:0] == fmdu_pkg::OP_NORM_MUL
                            && (df == 27'h0 || fmdu_pkg::fmdu_frac(r.mq) == 27'h0)) begin
                            n.ac = {sgn, 35'h0};
                            n.mq = {sgn, 35'h0};
                        end else begin
                            ch = fmdu_pkg::fmdu_char_calc(fmdu_pkg::fmdu_char(r.sr),
                                fmdu_pkg::fmdu_char(r.mq), 1'b0, fmdu_pkg::CHAR_NEG_BIAS);
                            n.ac[fmdu_pkg::CHAR_HI:fmdu_pkg::CHAR_LO] = ch[7:0];
                            if (ch[9]) n.unf = 1'b1;
                            if (!ch[9] && ch[8]) n.ovf = 1'b1;
                            // Zero counter still lets the characteristics add
                            if (pwdata[1:0] == fmdu_pkg::OP_UNNORM_MUL
                                && fmdu_pkg::fmdu_frac(r.mq) == 27'h0) begin
                                n.sc = 5'h0;
                            end else begin
                                n.sc = fmdu_pkg::FRAC_STEPS;
                            end
                            n.st = fmdu_pkg::ST_MUL;
                        end
                    end else begin
                        // Divide: AC is the dividend, SR the divisor
                        sgn = r.ac[fmdu_pkg::SIGN_BIT] ^ r.sr[fmdu_pkg::SIGN_BIT];
                        n.mq = {sgn, 35'h0};
                        big = {1'b0, af} >= {df, 1'b0};
                        if (af == 27'h0) begin
                            n.ac[fmdu_pkg::SIGN_BIT:fmdu_pkg::CHAR_LO] = 9'h0;
                            if (big) begin
                                n.dchk = 1'b1;
                                if (pwdata[1:0] == fmdu_pkg::OP_DIV_HALT) n.halt = 1'b1;
                            end
                        end else if (big) begin
                            // Accumulator left as it was
                            n.dchk = 1'b1;
                            if (pwdata[1:0] == fmdu_pkg::OP_DIV_HALT) n.halt = 1'b1;
                        end else begin
                            q1 = af >= df;
                            ch = fmdu_pkg::fmdu_char_calc(fmdu_pkg::fmdu_char(r.ac),
                                fmdu_pkg::fmdu_char(r.sr), 1'b1,
                                fmdu_pkg::CHAR_BIAS + {9'h0, q1});
                            mqc = fmdu_pkg::fmdu_char_calc(fmdu_pkg::fmdu_char(r.ac), 8'h00,
                                1'b0, fmdu_pkg::CHAR_M27 + {9'h0, q1});
                            if (ch[9] || mqc[9]) n.unf = 1'b1;
                            if ((!ch[9] && ch[8]) || (!mqc[9] && mqc[8])) n.ovf = 1'b1;
                            n.mq[fmdu_pkg::CHAR_HI:fmdu_pkg::CHAR_LO] = ch[7:0];
                            n.rchar = mqc[7:0];
                            // Without q >= 1 the dividend moves up one place first
                            n.rem = q1 ? {1'b0, af} : {af, 1'b0};
                            n.sc = fmdu_pkg::FRAC_STEPS;
                            n.st = fmdu_pkg::ST_DIV;
                        end
                    end
                end
            end
            fmdu_pkg::ST_MUL: begin
                // Single-cycle array product; a zero counter forces zero
                if (r.sc != 5'h0) begin
                    prod = {27'h0, df} * {27'h0, fmdu_pkg::fmdu_frac(r.mq)};
                end
                n.ac[fmdu_pkg::FRAC_HI:0] = prod[53:27];
                n.mq[fmdu_pkg::FRAC_HI:0] = prod[26:0];
                n.sc = 5'h0;
                n.st = fmdu_pkg::ST_MNORM;
            end
            fmdu_pkg::ST_MNORM: begin
                hl = {fmdu_pkg::fmdu_frac(r.ac), fmdu_pkg::fmdu_frac(r.mq)};
                ch = {2'h0, fmdu_pkg::fmdu_char(r.ac)};
                // Unnormalized multiply skips this shift
                if (r.op == fmdu_pkg::OP_NORM_MUL && !hl[53]) begin
                    hl = {hl[52:0], 1'b0};
                    ch = fmdu_pkg::fmdu_char_calc(ch[7:0], 8'h01, 1'b1, 10'h000);
                end
                n.ac[fmdu_pkg::FRAC_HI:0] = hl[53:27];
                n.mq[fmdu_pkg::FRAC_HI:0] = hl[26:0];
                if (r.op == fmdu_pkg::OP_NORM_MUL && hl[53:27] == 27'h0) begin
                    n.ac[fmdu_pkg::CHAR_HI:fmdu_pkg::CHAR_LO] = 8'h00;
                    n.mq[fmdu_pkg::CHAR_HI:fmdu_pkg::CHAR_LO] = 8'h00;
                end else begin
                    mqc = fmdu_pkg::fmdu_char_calc(ch[7:0], 8'h00, 1'b0, fmdu_pkg::CHAR_M27);
                    n.ac[fmdu_pkg::CHAR_HI:fmdu_pkg::CHAR_LO] = ch[7:0];
                    n.mq[fmdu_pkg::CHAR_HI:fmdu_pkg::CHAR_LO] = mqc[7:0];
                    if (ch[9] || mqc[9]) n.unf = 1'b1;
                end
                n.st = fmdu_pkg::ST_IDLE;
            end
            fmdu_pkg::ST_DIV: begin
                // One restoring reduction per clock; quotient is left unnormalized
                ge = r.rem >= {1'b0, df};
                trial = ge ? (r.rem - {1'b0, df}) : r.rem;
                n.mq[fmdu_pkg::FRAC_HI:0] = {r.mq[25:0], ge};
                n.sc = r.sc - 5'h01;
                if (r.sc == 5'h01) begin
                    n.ac = {r.ac[fmdu_pkg::SIGN_BIT], r.rchar, trial[26:0]};
                    n.st = fmdu_pkg::ST_IDLE;
                end else begin
                    n.rem = {trial[26:0], 1'b0};
                end
            end
            default: n.st = fmdu_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign machine_halt = r.halt;
    assign divide_check = r.dchk;
    assign fp_overflow = r.ovf;
    assign fp_underflow = r.unf;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_go_mul;
        go && !pwdata[1];
    endsequence

    sequence s_go_div;
        go && pwdata[1];
    endsequence

    sequence s_div_check;
        s_go_div ##0 ({1'b0, fmdu_pkg::fmdu_frac(r.ac)} >= {fmdu_pkg::fmdu_frac(r.sr), 1'b0});
    endsequence

    // Start edge, then characteristics, product and normalization: idle by the third
    a_mul_latency: assert property (s_go_mul |-> ##[1:3] (r.st == fmdu_pkg::ST_IDLE))
        else $error("multiply did not finish within three cycles");

    a_mul_sign_pair: assert property (s_go_mul |-> ##2 (r.ac[35] == r.mq[35]
        && r.ac[35] == $past(r.sr[35] ^ r.mq[35], 2)))
        else $error("product signs wrong");

    a_mul_zero_clear: assert property (s_go_mul ##0 (pwdata[1:0] == fmdu_pkg::OP_NORM_MUL)
        ##0 (fmdu_pkg::fmdu_frac(r.sr) == 27'h0)
        |=> (r.ac[34:0] == 35'h0 && r.mq[34:0] == 35'h0 && r.st == fmdu_pkg::ST_IDLE))
        else $error("zero multiplicand not cleared");

    a_mul_norm_msb: assert property (s_go_mul ##0 (pwdata[1:0] == fmdu_pkg::OP_NORM_MUL)
        ##0 (r.sr[26] && r.mq[26]) |-> ##3 r.ac[26])
        else $error("normal product not normalized");

    a_div_mq_clear: assert property (s_go_div |=> (r.mq[26:0] == 27'h0
        && r.mq[35] == $past(r.ac[35] ^ r.sr[35])))
        else $error("quotient register not cleared with algebraic sign");

    a_dchk_ac_hold: assert property (s_div_check ##0 (fmdu_pkg::fmdu_frac(r.ac) != 27'h0)
        |=> (r.dchk && r.ac == $past(r.ac) && r.st == fmdu_pkg::ST_IDLE))
        else $error("divide check did not hold accumulator");

    a_zero_dividend: assert property (s_go_div ##0 (fmdu_pkg::fmdu_frac(r.ac) == 27'h0)
        |=> (r.ac[35:27] == 9'h0 && r.mq[34:27] == 8'h00))
        else $error("zero dividend not made positive zero");

    a_halt_variant: assert property (s_div_check |=> (r.halt == ($past(pwdata[1:0])
        == fmdu_pkg::OP_DIV_HALT)))
        else $error("halt or proceed variant wrong");

    a_div_last_step: assert property ((r.st == fmdu_pkg::ST_DIV && r.sc == 5'h01)
        |=> (r.st == fmdu_pkg::ST_IDLE && r.sc == 5'h00))
        else $error("division did not end on last reduction");

    a_div_latency: assert property (s_go_div |-> ##[1:28] (r.st == fmdu_pkg::ST_IDLE))
        else $error("division exceeded 27 reductions");

endmodule : fmdu_top

// ===== verif/fmdu_host.sv
// Processor side model that loads and reads the unit's registers over APB
`timescale 1ns/10ps
module fmdu_host (
    // Clock
    input wire logic pclk,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ------------------------------------------------------------
    // Idle bus and single transfer
    // ------------------------------------------------------------
    // Defined levels from time zero
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // A released bus must not look like the last request
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : fmdu_host

// ===== verif/fmdu_top_tb.sv
// Self-checking bench for the floating multiply and divide unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module fmdu_top_tb;
    // ------------------------------------------------------------
    // Clock, reset, bus and counters
    // ------------------------------------------------------------
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic machine_halt, divide_check, fp_overflow, fp_underflow, err;
    logic [35:0] w;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int polls;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    fmdu_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    fmdu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .machine_halt(machine_halt), .divide_check(divide_check),
        .fp_overflow(fp_overflow), .fp_underflow(fp_underflow));

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Hang guard, well above the several hundred cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'h1, a, d, rd, err);
    endtask : wr32

    // A 36-bit word travels as low word then top four bits
    task automatic put(input logic [7:0] a, input logic [35:0] v);
        wr32(a, v[31:0]);
        wr32(a + 8'h04, {28'h0, v[35:32]});
    endtask : put

    task automatic get(input logic [7:0] a, output logic [35:0] v);
        i_host.xfer(1'h0, a, 32'h0, rd, err);
        v[31:0] = rd;
        i_host.xfer(1'h0, a + 8'h04, 32'h0, rd, err);
        v[35:32] = rd[3:0];
    endtask : get

    // Load operands, start, poll busy; the global guard bounds the wait
    task automatic run_op(input logic [1:0] op, input logic [35:0] ac, mq, sr);
        put(fmdu_pkg::AC_LO_OFF, ac);
        put(fmdu_pkg::MQ_LO_OFF, mq);
        put(fmdu_pkg::SR_LO_OFF, sr);
        wr32(fmdu_pkg::CTRL_OFF, {23'h0, 1'h1, 6'h0, op});
        polls = 0;
        do begin
            i_host.xfer(1'h0, fmdu_pkg::STATUS_OFF, 32'h0, rd, err);
            polls++;
        end while (rd[fmdu_pkg::ST_BUSY_BIT] !== 1'h0);
    endtask : run_op

    task automatic chk_res(input string nm, input logic [35:0] ac, mq);
        get(fmdu_pkg::AC_LO_OFF, w);
        `CHK({nm, " ac"}, ac, w)
        get(fmdu_pkg::MQ_LO_OFF, w);
        `CHK({nm, " mq"}, mq, w)
        $display("test %s done", nm);
    endtask : chk_res

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        i_host.xfer(1'h0, fmdu_pkg::STATUS_OFF, 32'h0, rd, err);
        `CHK("status reset", 32'h0, rd)
        // Normalizing multiply; the shift pulls the low half's top bit up
        run_op(fmdu_pkg::OP_NORM_MUL, 36'h0, {1'h1, 8'h80, 27'h4000000},
               {1'h0, 8'h81, 27'h4000001});
        chk_res("fmul", {1'h1, 8'h80, 27'h4000001}, {1'h1, 8'h65, 27'h0});
        // Same operands unnormalized: no shift
        run_op(fmdu_pkg::OP_UNNORM_MUL, 36'h0, {1'h1, 8'h80, 27'h4000000},
               {1'h0, 8'h81, 27'h4000001});
        chk_res("ufm", {1'h1, 8'h81, 27'h2000000}, {1'h1, 8'h66, 27'h4000000});
        // Zero multiplier ends early, signs still set
        run_op(fmdu_pkg::OP_NORM_MUL, {1'h0, 8'h77, 27'h123}, {1'h0, 8'h90, 27'h0},
               {1'h1, 8'h81, 27'h4000001});
        chk_res("fmul zero", {1'h1, 35'h0}, {1'h1, 35'h0});
        // Unnormalized zero multiplier keeps characteristic sum
        run_op(fmdu_pkg::OP_UNNORM_MUL, 36'h0, {1'h0, 8'h90, 27'h0},
               {1'h0, 8'h81, 27'h4000001});
        chk_res("ufm zero", {1'h0, 8'h91, 27'h0}, {1'h0, 8'h76, 27'h0});
        // Divide with pre-shift; stale quotient register must be cleared
        run_op(fmdu_pkg::OP_DIV_PROCEED, {1'h0, 8'h85, 27'h2000000}, {1'h0, 8'h11, 27'h5},
               {1'h1, 8'h82, 27'h4000000});
        `CHK("div time", 1'h1, polls <= 10)
        chk_res("fdiv", {1'h0, 8'h6a, 27'h0}, {1'h1, 8'h83, 27'h4000000});
        // Quotient of one: characteristics one higher
        run_op(fmdu_pkg::OP_DIV_HALT, {1'h1, 8'h85, 27'h4000000}, 36'h0,
               {1'h1, 8'h82, 27'h4000000});
        chk_res("fdiv q1", {1'h1, 8'h6b, 27'h0}, {1'h0, 8'h84, 27'h4000000});
        `CHK("no check", 1'h0, divide_check)
        // Divide check, proceed variant: AC kept, signed zero quotient
        run_op(fmdu_pkg::OP_DIV_PROCEED, {1'h1, 8'h85, 27'h4000000}, 36'h0,
               {1'h0, 8'h82, 27'h2000000});
        chk_res("fdp chk", {1'h1, 8'h85, 27'h4000000}, {1'h1, 35'h0});
        `CHK("dchk set", 1'h1, divide_check)
        `CHK("no halt", 1'h0, machine_halt)
        wr32(fmdu_pkg::STATUS_OFF, 32'h1e);
        // The clear lands on the edge the task returns at; look once it has settled
        @(negedge pclk);
        `CHK("dchk clear", 1'h0, divide_check)
        // Halt variant stops; a later start is ignored
        run_op(fmdu_pkg::OP_DIV_HALT, {1'h1, 8'h85, 27'h4000000}, 36'h0,
               {1'h0, 8'h82, 27'h2000000});
        `CHK("halted", 1'h1, machine_halt)
        run_op(fmdu_pkg::OP_NORM_MUL, {1'h0, 8'h44, 27'h7}, {1'h0, 8'h81, 27'h4000000},
               {1'h0, 8'h81, 27'h4000000});
        chk_res("halt hold", {1'h0, 8'h44, 27'h7}, {1'h0, 8'h81, 27'h4000000});
        wr32(fmdu_pkg::STATUS_OFF, 32'h1e);
        @(negedge pclk);
        `CHK("halt clear", 1'h0, machine_halt)
        // Zero dividend with zero divisor: positive zero and check
        run_op(fmdu_pkg::OP_DIV_PROCEED, {1'h1, 8'h85, 27'h0}, 36'h5,
               {1'h1, 8'h82, 27'h0});
        chk_res("fdiv zero", 36'h0, 36'h0);
        `CHK("zero dchk", 1'h1, divide_check)
        // Characteristic range exits
        run_op(fmdu_pkg::OP_NORM_MUL, 36'h0, {1'h0, 8'hff, 27'h4000000},
               {1'h0, 8'hff, 27'h4000000});
        `CHK("overflow", 1'h1, fp_overflow)
        run_op(fmdu_pkg::OP_NORM_MUL, 36'h0, {1'h0, 8'h01, 27'h4000000},
               {1'h0, 8'h01, 27'h4000000});
        `CHK("underflow", 1'h1, fp_underflow)
        // Unmapped and misaligned addresses are refused
        i_host.xfer(1'h0, 8'h20, 32'h0, rd, err);
        `CHK("unmapped err", 1'h1, err)
        `CHK("unmapped data", 32'h0, rd)
        i_host.xfer(1'h1, 8'h02, 32'hffffffff, rd, err);
        `CHK("misaligned err", 1'h1, err)
        $display("test bus errors done");
        finish_test();
    end
endmodule : fmdu_top_tb
